// >>> hw/wmg_consts.vh
// Constants and register map for the wake input measurement gating block
//
// Functional notes
// - Measurement operative only in normal mode
// - Measure enable bit cleared after reset
// - Disabled: normal wake, level, switch open
// - Enabled and normal mode: switch closed
// - Enabled, other modes: switch held open
// - Enabled: both pull sources forced off
// - Enabled: input detection signals gated off
// - Enabled: pull/filter/wake settings ignored, writable
// - Enabled: no status or level updates
// - Sleep with only measured sources: error, restart
// - Short filter nominally 16 us
// - Long filter nominally 64 us
// - Filter field: 16us, 64us, cyclic T1/T2
// - Wake only if level stable through filter
// - Pull field: none, down, up, automatic
`ifndef WMG_CONSTS_VH
`define WMG_CONSTS_VH

`define WMG_ADR_CTRL      4'h0
`define WMG_ADR_PULL      4'h1
`define WMG_ADR_FILT      4'h2
`define WMG_ADR_WKEN      4'h3
`define WMG_ADR_WSTAT     4'h4
`define WMG_ADR_LVL       4'h5
`define WMG_ADR_IRQ_STAT  4'h6
`define WMG_ADR_IRQ_MASK  4'h7
`define WMG_ADR_MODE      4'h8

`define WMG_CTRL_MEAS_BIT 0
`define WMG_CTRL_RST      1'b0
`define WMG_PULL_RST      4'h0
`define WMG_FILT_RST      4'h0
`define WMG_WKEN_RST      2'h0
`define WMG_MASK_RST      2'h0

`define WMG_MODE_NORMAL   3'h0
`define WMG_MODE_STOP     3'h1
`define WMG_MODE_SLEEP    3'h2
`define WMG_MODE_RESTART  3'h3

`define WMG_PULL_NONE     2'h0
`define WMG_PULL_DOWN     2'h1
`define WMG_PULL_UP       2'h2
`define WMG_PULL_AUTO     2'h3

`define WMG_CLK_MHZ       40
`define WMG_T_SHORT_US    16
`define WMG_T_LONG_US     64
`define WMG_CYC_SHORT     (`WMG_T_SHORT_US * `WMG_CLK_MHZ)
`define WMG_CYC_LONG      (`WMG_T_LONG_US * `WMG_CLK_MHZ)

`endif

// >>> hw/wmg_top.v
// Wake input measurement gating with Wishbone registers
`timescale 1ns/1ps
`default_nettype none
`include "wmg_consts.vh"

module wmg_top (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [3:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire [1:0]  hv_input_i,
    input  wire [1:0]  cyc_window_i,
    input  wire [2:0]  mode_i,
    input  wire        sleep_cmd_i,
    input  wire        other_wake_src_i,
    output reg         measure_switch_o,
    output reg  [1:0]  pull_up_en_o,
    output reg  [1:0]  pull_down_en_o,
    output reg         cmd_error_o,
    output reg         restart_req_o,
    output reg         sleep_ok_o,
    output reg         irq_o
);

    reg        measure_enable_bit_q;
    reg [3:0]  pull_config_register_q;
    reg [3:0]  filter_config_register_q;
    reg [1:0]  wake_enable_register_q;
    reg [1:0]  wake_source_status_q;
    reg [1:0]  input_level_status_q;
    reg [1:0]  irq_stat_q;
    reg [1:0]  irq_mask_q;
    reg [1:0]  wake_evt;

    wire       meas_on = measure_enable_bit_q;
    wire       normal  = (mode_i == `WMG_MODE_NORMAL);
    wire       wr      = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0] & ce_i;
    wire       rd_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
    // Only-measured-source sleep attempt
    wire       bad_sleep = sleep_cmd_i & meas_on & (|wake_enable_register_q)
                           & ~other_wake_src_i;
    wire       sleep_err_evt = bad_sleep & ce_i;
    // Filter end counts, cut to the counter width on purpose
    localparam [31:0] LIM_SHORT_W = `WMG_CYC_SHORT - 1;
    localparam [31:0] LIM_LONG_W  = `WMG_CYC_LONG - 1;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_ch
            reg        lvl_q;
            reg [11:0] cnt_q;
            reg        run_q;
            wire [1:0] flt   = filter_config_register_q[2*g+1:2*g];
            wire [1:0] pull  = pull_config_register_q[2*g+1:2*g];
            // Gated detection signal
            wire       sense = hv_input_i[g] & ~meas_on;
            wire       cyc_ok = ~flt[1] | cyc_window_i[g];
            wire [11:0] lim  = (flt == 2'h1) ? LIM_LONG_W[11:0]
                                             : LIM_SHORT_W[11:0];
            always @(posedge clk_i) begin
                if (rst_i) begin
                    lvl_q <= 1'b0;
                    cnt_q <= 12'h000;
                    run_q <= 1'b0;
                end else if (ce_i) begin
                    if (meas_on) begin
                        run_q <= 1'b0;
                        cnt_q <= 12'h000;
                    end else if (!cyc_ok) begin
                        run_q <= 1'b0;
                    end else if (sense != lvl_q && !run_q) begin
                        run_q <= 1'b1;
                        cnt_q <= 12'h000;
                    end else if (run_q) begin
                        if (sense == lvl_q) begin
                            run_q <= 1'b0;
                        end else if (cnt_q == lim) begin
                            run_q <= 1'b0;
                            lvl_q <= sense;
                        end else begin
                            cnt_q <= cnt_q + 12'h001;
                        end
                    end
                end
            end
            always @* begin
                wake_evt[g] = ce_i & run_q & ~meas_on & cyc_ok & (sense != lvl_q) & (cnt_q == lim)
                              & wake_enable_register_q[g];
            end
            always @(posedge clk_i) begin
                if (rst_i) begin
                    pull_up_en_o[g]   <= 1'b0;
                    pull_down_en_o[g] <= 1'b0;
                end else if (ce_i) begin
                    if (meas_on) begin
                        pull_up_en_o[g]   <= 1'b0;
                        pull_down_en_o[g] <= 1'b0;
                    end else begin
                        pull_up_en_o[g]   <= (pull == `WMG_PULL_UP) |
                                             ((pull == `WMG_PULL_AUTO) & lvl_q);
                        pull_down_en_o[g] <= (pull == `WMG_PULL_DOWN) |
                                             ((pull == `WMG_PULL_AUTO) & ~lvl_q);
                    end
                end
            end
            always @(posedge clk_i) begin
                if (rst_i) begin
                    input_level_status_q[g] <= 1'b0;
                end else if (ce_i && !meas_on && cyc_ok) begin
                    input_level_status_q[g] <= lvl_q;
                end
            end
        end
    endgenerate

    // Switch follows bit and mode; registered from the current bit and mode, one cycle behind them
    always @(posedge clk_i) begin
        if (rst_i) begin
            measure_switch_o <= 1'b0;
        end else if (ce_i) begin
            measure_switch_o <= measure_enable_bit_q & normal;
        end
    end

    // Sleep command outcome
    always @(posedge clk_i) begin
        if (rst_i) begin
            cmd_error_o   <= 1'b0;
            restart_req_o <= 1'b0;
            sleep_ok_o    <= 1'b0;
        end else if (ce_i) begin
            restart_req_o <= bad_sleep;
            sleep_ok_o    <= sleep_cmd_i & ~bad_sleep;
            if (bad_sleep) begin
                cmd_error_o <= 1'b1;
            end else if (wr && wb_adr_i == `WMG_ADR_CTRL && wb_dat_i[1]) begin
                cmd_error_o <= 1'b0;
            end
        end
    end

    // Register writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            measure_enable_bit_q     <= `WMG_CTRL_RST;
            pull_config_register_q   <= `WMG_PULL_RST;
            filter_config_register_q <= `WMG_FILT_RST;
            wake_enable_register_q   <= `WMG_WKEN_RST;
            irq_mask_q               <= `WMG_MASK_RST;
        end else if (wr) begin
            case (wb_adr_i)
                `WMG_ADR_CTRL: measure_enable_bit_q <= wb_dat_i[`WMG_CTRL_MEAS_BIT];
                `WMG_ADR_PULL: pull_config_register_q <= wb_dat_i[3:0];
                `WMG_ADR_FILT: filter_config_register_q <= wb_dat_i[3:0];
                `WMG_ADR_WKEN: wake_enable_register_q <= wb_dat_i[1:0];
                `WMG_ADR_IRQ_MASK: irq_mask_q <= wb_dat_i[1:0];
                default: ;
            endcase
        end
    end

    // Sticky status: set wins over write-one-to-clear
    wire       clr_ws = wr && (wb_adr_i == `WMG_ADR_WSTAT);
    wire       clr_is = wr && (wb_adr_i == `WMG_ADR_IRQ_STAT);
    wire [1:0] irq_ev = {sleep_err_evt, |wake_evt};
    wire [1:0] irq_nx = (irq_stat_q & ~({2{clr_is}} & wb_dat_i[1:0])) | irq_ev;
    always @(posedge clk_i) begin
        if (rst_i) begin
            wake_source_status_q <= 2'h0;
            irq_stat_q           <= 2'h0;
            irq_o                <= 1'b0;
        end else if (ce_i) begin
            wake_source_status_q <= (wake_source_status_q & ~({2{clr_ws}} & wb_dat_i[1:0]))
                                    | wake_evt;
            irq_stat_q <= irq_nx;
            irq_o      <= |(irq_nx & irq_mask_q);
        end
    end

    // Bus answer: ack one cycle after request
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else if (ce_i) begin
            wb_ack_o <= rd_req;
            wb_dat_o <= 32'h00000000;
            if (rd_req && !wb_we_i) begin
                case (wb_adr_i)
                    `WMG_ADR_CTRL:     wb_dat_o <= {30'h0, cmd_error_o, measure_enable_bit_q};
                    `WMG_ADR_PULL:     wb_dat_o <= {28'h0, pull_config_register_q};
                    `WMG_ADR_FILT:     wb_dat_o <= {28'h0, filter_config_register_q};
                    `WMG_ADR_WKEN:     wb_dat_o <= {30'h0, wake_enable_register_q};
                    `WMG_ADR_WSTAT:    wb_dat_o <= {30'h0, wake_source_status_q};
                    `WMG_ADR_LVL:      wb_dat_o <= {30'h0, input_level_status_q};
                    `WMG_ADR_IRQ_STAT: wb_dat_o <= {30'h0, irq_stat_q};
                    `WMG_ADR_IRQ_MASK: wb_dat_o <= {30'h0, irq_mask_q};
                    `WMG_ADR_MODE:     wb_dat_o <= {29'h0, mode_i};
                    default:           wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // wmg_top
`default_nettype wire

// >>> dv/wmg_host.sv
// Wishbone host model standing in for the microcontroller
`timescale 1ns/1ps
`default_nettype none
module wmg_host (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output var  logic        cyc_o,
    output var  logic        we_o,
    output var  logic [3:0]  adr_o,
    output var  logic [31:0] dat_o
);
    initial begin
        cyc_o = 1'b0;
        we_o = 1'b0;
        adr_o = 4'h0;
        dat_o = 32'h0;
    end
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        q = dat_i;
        cyc_o <= 1'b0;
        we_o <= 1'b0;
        dat_o <= ~d; // Released data does not keep its last value
    endtask
endmodule // wmg_host
`default_nettype wire

// >>> dv/wmg_top_properties.sv
// Property checker for the measurement gating block
`timescale 1ns/1ps
`default_nettype none
module wmg_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic [2:0]  mode_i,
    input wire logic        sleep_cmd_i,
    input wire logic        other_wake_src_i,
    input wire logic        measure_switch_o,
    input wire logic [1:0]  pull_up_en_o,
    input wire logic [1:0]  pull_down_en_o,
    input wire logic        cmd_error_o,
    input wire logic        restart_req_o,
    input wire logic        sleep_ok_o
);
    logic       en_q;
    logic [1:0] wk_q;
    wire        wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    wire        bad = en_q & (|wk_q) & ~other_wake_src_i;
    // Mirror of enable bit and wake enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_q <= 1'b0;
            wk_q <= 2'h0;
        end else if (wr && wb_adr_i == 4'h0) begin
            en_q <= wb_dat_i[0];
        end else if (wr && wb_adr_i == 4'h3) begin
            wk_q <= wb_dat_i[1:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_bad_sleep;
        sleep_cmd_i && bad;
    endsequence
    a_sw_mode: assert property (
        measure_switch_o == $past(en_q && mode_i == 3'h0)) else $error("switch wrong");
    a_rst_clear: assert property ($fell(rst_i) |-> !measure_switch_o && !cmd_error_o)
        else $error("not clear after reset");
    a_pull_off: assert property (en_q && $past(en_q) |-> !pull_up_en_o && !pull_down_en_o)
        else $error("pull active while measuring");
    a_err_set: assert property (s_bad_sleep |=> restart_req_o && cmd_error_o)
        else $error("sleep error missed");
    a_sleep_ok: assert property (sleep_cmd_i && !bad |=> sleep_ok_o && !restart_req_o)
        else $error("sleep refused");
    a_restart_cause: assert property (restart_req_o |-> $past(sleep_cmd_i && bad))
        else $error("restart without cause");
    a_err_sticky: assert property (
        cmd_error_o && !(wr && wb_adr_i == 4'h0 && wb_dat_i[1]) |=> cmd_error_o)
        else $error("error bit lost");
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
endmodule // wmg_props
bind wmg_top wmg_props u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .mode_i(mode_i), .sleep_cmd_i(sleep_cmd_i),
    .other_wake_src_i(other_wake_src_i), .measure_switch_o(measure_switch_o),
    .pull_up_en_o(pull_up_en_o), .pull_down_en_o(pull_down_en_o),
    .cmd_error_o(cmd_error_o), .restart_req_o(restart_req_o), .sleep_ok_o(sleep_ok_o));
`default_nettype wire

// >>> dv/wmg_top_bench.sv
// Self-checking bench for the measurement gating block
`timescale 1ns/1ps
`default_nettype none
module wmg_top_bench;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc, we, ack, sc = 1'b0, ow = 1'b0;
    logic        sw, err, rr, sok, irq;
    logic [1:0]  hv = 2'h0, pu, pd;
    logic [2:0]  mode = 3'h0;
    logic [3:0]  adr;
    logic [31:0] wdat, rdat, q;
    int          err_count = 0, tests_run = 0, seed = 32'h01f8e153, m_en = 0, m_wk = 0;
    always #12.5 clk_i = ~clk_i;
    wmg_host host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
        .adr_o(adr), .dat_o(wdat));
    wmg_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .hv_input_i(hv), .cyc_window_i(2'h0), .mode_i(mode),
        .sleep_cmd_i(sc), .other_wake_src_i(ow), .measure_switch_o(sw), .pull_up_en_o(pu),
        .pull_down_en_o(pd), .cmd_error_o(err), .restart_req_o(rr), .sleep_ok_o(sok),
        .irq_o(irq));
    task automatic end_sim();
        $display("Comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        host.xfer(1'b0, a, 32'h0, q);
        chk($sformatf("reg %h", a), e, q);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, q);
    endtask
    task automatic modes();
        logic [2:0] m;
        repeat (24) begin
            m = 3'({$random(seed)} % 4);
            @(posedge clk_i);
            mode <= m;
            @(posedge clk_i);
            #1;
            chk("switch", 32'(m_en != 0 && m == 3'h0), {31'h0, sw});
        end
        mode <= 3'h0;
    endtask
    task automatic sleep_try(input logic o);
        logic bad;
        bad = m_en != 0 && m_wk != 0 && !o;
        @(posedge clk_i);
        sc <= 1'b1;
        ow <= o;
        @(posedge clk_i);
        sc <= 1'b0;
        #1;
        chk("restart", 32'(bad), {31'h0, rr});
        chk("sleep ok", 32'(!bad), {31'h0, sok});
    endtask
    initial begin
        #500000;
        err_count++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h3, 32'h0);
        wr(4'hC, 32'hFFFFFFFF);
        rd(4'hC, 32'h0);
        modes();
        wr(4'h1, 32'hA);
        wr(4'h3, 32'h3);
        m_wk = 3;
        hv <= 2'h1;
        repeat (600) @(posedge clk_i);
        chk("pull up", 32'h3, {30'h0, pu});
        rd(4'h4, 32'h0);
        repeat (60) @(posedge clk_i);
        rd(4'h4, 32'h1);
        rd(4'h5, 32'h1);
        wr(4'h4, 32'h3);
        wr(4'h6, 32'h3);
        rd(4'h4, 32'h0);
        $display("Wake filter test done");
        wr(4'h0, 32'h1);
        m_en = 1;
        @(posedge clk_i);
        #1;
        chk("pulls", 32'h0, {30'h0, pu | pd});
        rd(4'h1, 32'hA);
        hv <= 2'h2;
        repeat (700) @(posedge clk_i);
        rd(4'h4, 32'h0);
        rd(4'h5, 32'h1);
        modes();
        sleep_try(1'b1);
        sleep_try(1'($random(seed)));
        sleep_try(1'b0);
        rd(4'h0, 32'h3);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(4'h7, 32'h3);
        @(posedge clk_i);
        #1;
        chk("irq", 32'h1, {31'h0, irq});
        wr(4'h6, 32'h3);
        wr(4'h7, 32'h0);
        rd(4'h6, 32'h0);
        wr(4'h0, 32'h3);
        rd(4'h0, 32'h1);
        $display("Measurement and sleep test done");
        end_sim();
    end
endmodule // wmg_top_bench
`default_nettype wire
